// ===== inc/ddr_fifo_defs.svh
`ifndef DDR_FIFO_DEFS_SVH
`define DDR_FIFO_DEFS_SVH

// ---------------------------------------------------------------------------
// widths
// ---------------------------------------------------------------------------
`define WORD_W        32            // data word width
`define ADDR_W        25            // word address into one bank
`define LEVEL_W       26            // words held in one bank
`define FILL_W        5             // staging fifo fill count width
`define PTR_W         4             // staging fifo pointer width

// ---------------------------------------------------------------------------
// depths and sizes
// ---------------------------------------------------------------------------
`define DEEP_WORDS    26'h2000000   // locations in one bank
`define DEEP_ROOM     26'h1fffffe   // last level that still takes a pair
`define PAIR_WORDS    26'h0000002   // words moved per memory request
`define PAIR_STEP     25'h0000002   // address advance per pair
`define ASYNC_DEPTH   15            // port side staging fifo entries
`define STAGE_DEPTH   16            // memory side staging fifo entries
`define IN_ROOM       5'h0e         // async fill below which input is ready

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define CLK_MHZ       125           // system clock rate in MHz
`define STRETCH_MS    50            // least time a status lamp stays lit
`define BLINK_MS      250           // heartbeat half period
`define STRETCH_CNT   8'h32         // stretch time in ms ticks
`define BLINK_CNT     8'hfa         // blink half period in ms ticks

`endif

// ===== inc/ddr_fifo_pkg.sv
// ---------------------------------------------------------------------------
// shared types
// ---------------------------------------------------------------------------
`include "ddr_fifo_defs.svh"

package ddr_fifo_pkg;
    typedef logic [`WORD_W-1:0]  word_type;   // one data word
    typedef logic [`ADDR_W-1:0]  addr_type;   // bank word address
    typedef logic [`LEVEL_W-1:0] level_type;  // bank occupancy
    typedef logic [`FILL_W-1:0]  fill_type;   // staging fill count
endpackage

// ===== inc/stage_if.sv
// ---------------------------------------------------------------------------
// valid/ready word stream between staging fifos
// ---------------------------------------------------------------------------
interface stage_if;
    ddr_fifo_pkg::word_type data;   // word on offer
    logic                   valid;  // word present
    logic                   ready;  // taker accepts this cycle

    modport sink   (input data, input valid, output ready);
    modport source (output data, output valid, input ready);
endinterface

// ===== hdl/stage_fifo.sv
`include "ddr_fifo_defs.svh"

// ---------------------------------------------------------------------------
// small staging fifo, read word held in an output register
// ---------------------------------------------------------------------------
module stage_fifo #(
    parameter int DEPTH = `STAGE_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    stage_if.sink                  pushSide,
    stage_if.source                popSide,
    output ddr_fifo_pkg::fill_type fill
);
    ddr_fifo_pkg::word_type mem [0:DEPTH-1];  // storage
    logic [`PTR_W-1:0]      wp;               // write pointer
    logic [`PTR_W-1:0]      rp;               // read pointer
    logic [`FILL_W-1:0]     memCount;         // words in storage

    // pointer advance with wrap at depth
    function automatic logic [`PTR_W-1:0] nextPtr(input logic [`PTR_W-1:0] p);
        nextPtr = (p == `PTR_W'(DEPTH - 1)) ? '0 : p + `PTR_W'(1);
    endfunction

    // decode of moves
    wire doPush  = pushSide.valid && pushSide.ready;
    wire loadOut = (memCount != '0) && (!popSide.valid || popSide.ready);
    wire dropOut = popSide.valid && popSide.ready && (memCount == '0);

    // fill counts the output register too
    assign fill          = memCount + {{(`FILL_W-1){1'b0}}, popSide.valid};
    assign pushSide.ready = (fill < `FILL_W'(DEPTH));

    // storage write, no reset needed
    always_ff @(posedge clk)
    begin
        if (doPush)
            mem[wp] <= pushSide.data;
    end

    // pointers, count and output register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp            <= '0;
            rp            <= '0;
            memCount      <= '0;
            popSide.valid <= 1'b0;
            popSide.data  <= '0;
        end
        else
        begin
            if (doPush)
                wp <= nextPtr(wp);
            if (loadOut)
            begin
                rp            <= nextPtr(rp);
                popSide.data  <= mem[rp];
                popSide.valid <= 1'b1;
            end
            else if (dropOut)
                popSide.valid <= 1'b0;
            memCount <= memCount + {{(`FILL_W-1){1'b0}}, doPush}
                                 - {{(`FILL_W-1){1'b0}}, loadOut};
        end
    end
endmodule // stage_fifo

// ===== hdl/led_stretch.sv
`include "ddr_fifo_defs.svh"

// ---------------------------------------------------------------------------
// holds a status lamp lit for a least visible time
// ---------------------------------------------------------------------------
module led_stretch (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic msTick,
    input  wire logic cond,
    output logic      lamp
);
    logic [7:0] hold;   // ms left to stay lit

    // reload while the condition holds, count down after
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold <= 8'h00;
            lamp <= 1'b0;
        end
        else
        begin
            if (cond)
                hold <= `STRETCH_CNT;
            else if (msTick && hold != 8'h00)
                hold <= hold - 8'h01;
            lamp <= cond || (hold != 8'h00);
        end
    end
endmodule // led_stretch

// ===== hdl/dual_ddr_backed_fifo.sv
// Function
// - input port 0 flows through buffer A
// - input port 1 flows through buffer B
// - each buffer: 32-bit words, 32M bank locations
// - write path: 15x32 fifo then two stagers
// - write stagers feed memory interface directly
// - read path: two stagers then 15x32 fifo
// - total depth 33554526 words per path
// - lamps 0/1 show buffer A empty/full
// - lamps 2/3 show buffer B empty/full
// - counter stretches each status lamp visibly
// - lamp 4 toggles as port heartbeat
// - port rate full or halved, build choice
// - port rate 125 or 62.5 MHz at the 125 MHz clock
// - memory side runs on one fast clock
// - two words per cycle to memory
// - write words steered rise then fall
// - address counters, occupancy tracking per bank
`include "ddr_fifo_defs.svh"

module dual_ddr_backed_fifo #(
    parameter bit HALF_RATE  = 1'b0,              // port at half rate
    parameter int MS_CYCLES  = `CLK_MHZ * 1000    // clocks per millisecond
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire ddr_fifo_pkg::word_type [1:0] inData,
    input  wire logic [1:0]                   inValid,
    output logic [1:0]                        inReady,
    output ddr_fifo_pkg::word_type [1:0]      outData,
    output logic [1:0]                        outValid,
    input  wire logic [1:0]                   outReady,
    output logic                              portEnable,
    output logic [1:0]                        wrReq,
    output ddr_fifo_pkg::addr_type [1:0]      wrAddr,
    output ddr_fifo_pkg::word_type [1:0]      wrRise,
    output ddr_fifo_pkg::word_type [1:0]      wrFall,
    input  wire logic [1:0]                   wrAccept,
    output logic [1:0]                        rdReq,
    output ddr_fifo_pkg::addr_type [1:0]      rdAddr,
    input  wire logic [1:0]                   rdAccept,
    input  wire ddr_fifo_pkg::word_type [1:0] rdRise,
    input  wire ddr_fifo_pkg::word_type [1:0] rdFall,
    input  wire logic [1:0]                   rdReturn,
    output logic [4:0]                        lamp
);

    // -----------------------------------------------------------------------
    // rate enables
    // -----------------------------------------------------------------------
    logic        portTick;   // port side transfer enable
    logic [16:0] msCount;    // millisecond divider
    logic        msTick;     // one pulse per millisecond
    logic [7:0]  blinkCount; // heartbeat half period count
    logic        beat;       // heartbeat level

    assign portEnable = portTick;
    assign lamp[4]    = beat;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            portTick <= 1'b0;
        else if (HALF_RATE)
            portTick <= ~portTick;
        else
            portTick <= 1'b1;
    end
    // millisecond enable for lamps
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            msCount <= 17'h00000;
            msTick  <= 1'b0;
        end
        else
        begin
            msTick  <= (msCount == 17'(MS_CYCLES - 1));
            msCount <= (msCount == 17'(MS_CYCLES - 1)) ? 17'h00000
                                                       : msCount + 17'h00001;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            blinkCount <= 8'h00;
            beat       <= 1'b0;
        end
        else if (msTick)
        begin
            if (blinkCount == `BLINK_CNT - 8'h01)
            begin
                blinkCount <= 8'h00;
                beat       <= ~beat;
            end
            else
                blinkCount <= blinkCount + 8'h01;
        end
    end

    // -----------------------------------------------------------------------
    // one path per bank
    // -----------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : bank
            // stage links
            stage_if inPush ();
            stage_if asyncPop ();
            stage_if wRisePush ();
            stage_if wRisePop ();
            stage_if wFallPush ();
            stage_if wFallPop ();
            stage_if rRisePush ();
            stage_if rRisePop ();
            stage_if rFallPush ();
            stage_if rFallPop ();
            stage_if outPush ();
            stage_if outPop ();

            ddr_fifo_pkg::fill_type  asyncFill;  // port side fill
            ddr_fifo_pkg::fill_type  rRiseFill;  // read rise fill
            ddr_fifo_pkg::fill_type  rFallFill;  // read fall fill
            ddr_fifo_pkg::addr_type  wrPtr;      // next write address
            ddr_fifo_pkg::addr_type  rdPtr;      // next read address
            ddr_fifo_pkg::level_type usedLevel;  // words reserved in bank
            ddr_fifo_pkg::level_type readLevel;  // words safely written
            logic [`FILL_W-1:0]      inFlight;   // pairs asked, not back
            logic                    wrSel;      // next write goes to fall
            logic                    rdSel;      // next merge from fall

            // -------------------------------------------------------------
            // port input side
            // -------------------------------------------------------------
            // port words into the path
            assign inPush.data  = inData[g];
            assign inPush.valid = inValid[g] && inReady[g] && portTick;

            // ready only while room is left
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    inReady[g] <= 1'b0;
                else
                    inReady[g] <= (asyncFill < `IN_ROOM);
            end

            stage_fifo #(.DEPTH(`ASYNC_DEPTH)) asyncStage (
                .clk      (clk),
                .rst_b    (rst_b),
                .pushSide (inPush),
                .popSide  (asyncPop),
                .fill     (asyncFill)
            );

            // -------------------------------------------------------------
            // steering into rise and fall stagers
            // -------------------------------------------------------------
            // alternate rise then fall
            assign wRisePush.data  = asyncPop.data;
            assign wFallPush.data  = asyncPop.data;
            assign wRisePush.valid = asyncPop.valid && !wrSel;
            assign wFallPush.valid = asyncPop.valid && wrSel;
            assign asyncPop.ready  = wrSel ? wFallPush.ready
                                           : wRisePush.ready;
            // steering toggle
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    wrSel <= 1'b0;
                else if (asyncPop.valid && asyncPop.ready)
                    wrSel <= ~wrSel;
            end

            stage_fifo #(.DEPTH(`STAGE_DEPTH)) wRiseStage (
                .clk      (clk),
                .rst_b    (rst_b),
                .pushSide (wRisePush),
                .popSide  (wRisePop),
                .fill     ()
            );
            stage_fifo #(.DEPTH(`STAGE_DEPTH)) wFallStage (
                .clk      (clk),
                .rst_b    (rst_b),
                .pushSide (wFallPush),
                .popSide  (wFallPop),
                .fill     ()
            );

            // -------------------------------------------------------------
            // memory write requests
            // -------------------------------------------------------------
            // stop writes at full bank
            wire wrRoom = (usedLevel <= `DEEP_ROOM);
            wire wrSlot = !wrReq[g] || wrAccept[g];
            wire wrLoad = wRisePop.valid && wFallPop.valid && wrRoom && wrSlot;
            wire wrDone = wrReq[g] && wrAccept[g];

            assign wRisePop.ready = wrLoad;
            assign wFallPop.ready = wrLoad;
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    wrReq[g]  <= 1'b0;
                    wrAddr[g] <= '0;
                    wrRise[g] <= '0;
                    wrFall[g] <= '0;
                end
                else if (wrLoad)
                begin
                    wrReq[g]  <= 1'b1;
                    wrAddr[g] <= wrPtr;
                    wrRise[g] <= wRisePop.data;
                    wrFall[g] <= wFallPop.data;
                end
                else if (wrAccept[g])
                    wrReq[g] <= 1'b0;
            end

            // -------------------------------------------------------------
            // memory read requests
            // -------------------------------------------------------------
            wire rdAvail  = (readLevel >= `PAIR_WORDS);
            wire rdCredit = (rRiseFill + inFlight < `FILL_W'(`STAGE_DEPTH))
                         && (rFallFill + inFlight < `FILL_W'(`STAGE_DEPTH));
            wire rdSlot   = !rdReq[g] || rdAccept[g];
            wire rdLoad   = rdAvail && rdCredit && rdSlot;

            // read request held until taken
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    rdReq[g]  <= 1'b0;
                    rdAddr[g] <= '0;
                end
                else if (rdLoad)
                begin
                    rdReq[g]  <= 1'b1;
                    rdAddr[g] <= rdPtr;
                end
                else if (rdAccept[g])
                    rdReq[g] <= 1'b0;
            end

            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    wrPtr <= '0;
                    rdPtr <= '0;
                end
                else
                begin
                    if (wrLoad)
                        wrPtr <= wrPtr + `PAIR_STEP;
                    if (rdLoad)
                        rdPtr <= rdPtr + `PAIR_STEP;
                end
            end

            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    usedLevel <= '0;
                    readLevel <= '0;
                    inFlight  <= '0;
                end
                else
                begin
                    usedLevel <= usedLevel
                               + (wrLoad ? `PAIR_WORDS : '0)
                               - (rdLoad ? `PAIR_WORDS : '0);
                    readLevel <= readLevel
                               + (wrDone ? `PAIR_WORDS : '0)
                               - (rdLoad ? `PAIR_WORDS : '0);
                    inFlight  <= inFlight
                               + {{(`FILL_W-1){1'b0}}, rdLoad}
                               - {{(`FILL_W-1){1'b0}}, rdReturn[g]};
                end
            end

            // -------------------------------------------------------------
            // read stagers and merge
            // -------------------------------------------------------------
            assign rRisePush.data  = rdRise[g];
            assign rRisePush.valid = rdReturn[g];
            assign rFallPush.data  = rdFall[g];
            assign rFallPush.valid = rdReturn[g];

            stage_fifo #(.DEPTH(`STAGE_DEPTH)) rRiseStage (
                .clk      (clk),
                .rst_b    (rst_b),
                .pushSide (rRisePush),
                .popSide  (rRisePop),
                .fill     (rRiseFill)
            );
            stage_fifo #(.DEPTH(`STAGE_DEPTH)) rFallStage (
                .clk      (clk),
                .rst_b    (rst_b),
                .pushSide (rFallPush),
                .popSide  (rFallPop),
                .fill     (rFallFill)
            );

            // merge rise word then fall word
            assign outPush.data  = rdSel ? rFallPop.data : rRisePop.data;
            assign outPush.valid = rdSel ? rFallPop.valid : rRisePop.valid;
            assign rRisePop.ready = !rdSel && outPush.ready;
            assign rFallPop.ready = rdSel && outPush.ready;

            // merge toggle
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    rdSel <= 1'b0;
                else if (outPush.valid && outPush.ready)
                    rdSel <= ~rdSel;
            end

            stage_fifo #(.DEPTH(`ASYNC_DEPTH)) outStage (
                .clk      (clk),
                .rst_b    (rst_b),
                .pushSide (outPush),
                .popSide  (outPop),
                .fill     ()
            );

            // valid only with a word held
            assign outPop.ready = outReady[g] && portTick;
            assign outData[g]   = outPop.data;
            assign outValid[g]  = outPop.valid;

            // -------------------------------------------------------------
            // status lamps
            // -------------------------------------------------------------
            // empty lamp
            led_stretch emptyLamp (
                .clk    (clk),
                .rst_b  (rst_b),
                .msTick (msTick),
                .cond   (usedLevel == '0),
                .lamp   (lamp[2*g])
            );
            led_stretch fullLamp (
                .clk    (clk),
                .rst_b  (rst_b),
                .msTick (msTick),
                .cond   (usedLevel == `DEEP_WORDS),
                .lamp   (lamp[2*g+1])
            );
        end
    endgenerate

endmodule // dual_ddr_backed_fifo

// ===== test/dual_ddr_backed_fifo_props.sv
// ------------------------------
// port checks of the dual buffer
// ------------------------------
module dual_ddr_backed_fifo_props (
    input wire logic                         clk,
    input wire logic                         rst_b,
    input wire logic [1:0]                   inValid,
    input wire logic [1:0]                   inReady,
    input wire ddr_fifo_pkg::word_type [1:0] outData,
    input wire logic [1:0]                   outValid,
    input wire logic [1:0]                   outReady,
    input wire logic                         portEnable,
    input wire logic [1:0]                   wrReq,
    input wire ddr_fifo_pkg::addr_type [1:0] wrAddr,
    input wire logic [1:0]                   wrAccept,
    input wire logic [1:0]                   rdReq,
    input wire ddr_fifo_pkg::addr_type [1:0] rdAddr,
    input wire logic [1:0]                   rdAccept,
    input wire logic [4:0]                   lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [1:0] inTake  = inValid & inReady & {2{portEnable}};
    wire logic [1:0] outTake = outValid & outReady & {2{portEnable}};
    ddr_fifo_pkg::level_type [1:0] held;    // words inside each path
    ddr_fifo_pkg::addr_type        nextWr;  // next write address of bank A
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // occupancy and write address trackers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            held   <= '0;
            nextWr <= '0;
        end
        else
        begin
            held[0] <= held[0] + 26'(inTake[0]) - 26'(outTake[0]);
            held[1] <= held[1] + 26'(inTake[1]) - 26'(outTake[1]);
            nextWr  <= nextWr + ((wrReq[0] && wrAccept[0]) ? 25'h2 : 25'h0);
        end
    end
    a_empty_a: assert property (outValid[0] |-> held[0] != 26'h0)
        else $error("output A valid while path A holds nothing");
    a_empty_b: assert property (outValid[1] |-> held[1] != 26'h0)
        else $error("output B valid while path B holds nothing");
    a_out_hold: assert property (outValid[0] && !outTake[0] |=>
        outValid[0] && $stable(outData[0])) else $error("output A word lost");
    a_wr_hold: assert property (wrReq[0] && !wrAccept[0] |=>
        wrReq[0] && $stable(wrAddr[0])) else $error("write A dropped early");
    a_wr_order: assert property (wrReq[0] |-> wrAddr[0] == nextWr)
        else $error("write address A out of sequence");
    a_rd_hold: assert property (rdReq[1] && !rdAccept[1] |=>
        rdReq[1] && $stable(rdAddr[1])) else $error("read B dropped early");
    a_rd_gated: assert property (rdReq[0] |-> held[0] >= 26'h2)
        else $error("read A issued with under two words held");
    a_beat_slow: assert property ($changed(lamp[4]) |=>
        $stable(lamp[4]) [*8]) else $error("heartbeat toggles too fast");
endmodule // dual_ddr_backed_fifo_props

bind dual_ddr_backed_fifo dual_ddr_backed_fifo_props
    dual_ddr_backed_fifo_props_inst (.clk, .rst_b, .inValid, .inReady,
    .outData, .outValid, .outReady, .portEnable, .wrReq, .wrAddr, .wrAccept,
    .rdReq, .rdAddr, .rdAccept, .lamp);

// ===== test/ddr_bank_model.sv
// -------------------------------------
// memory controller stand-in, both banks
// -------------------------------------
module ddr_bank_model (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic [1:0]                   stall,
    input  wire logic [1:0]                   wrReq,
    input  wire ddr_fifo_pkg::addr_type [1:0] wrAddr,
    input  wire ddr_fifo_pkg::word_type [1:0] wrRise,
    input  wire ddr_fifo_pkg::word_type [1:0] wrFall,
    output logic [1:0]                        wrAccept,
    input  wire logic [1:0]                   rdReq,
    input  wire ddr_fifo_pkg::addr_type [1:0] rdAddr,
    output logic [1:0]                        rdAccept,
    output ddr_fifo_pkg::word_type [1:0]      rdRise,
    output ddr_fifo_pkg::word_type [1:0]      rdFall,
    output logic [1:0]                        rdReturn
);
    timeunit 1ns;
    timeprecision 1ps;
    ddr_fifo_pkg::word_type mem [int];  // sparse store, bank in bit 25
    // slow answers while stalled
    assign wrAccept = wrReq & ~stall;
    assign rdAccept = rdReq & ~stall;
    // pair returned the cycle after acceptance
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdReturn <= 2'h0;
            rdRise   <= '0;
            rdFall   <= '0;
        end
        else
            for (int g = 0; g < 2; g++)
            begin
                if (wrAccept[g])
                begin
                    mem[{g[0], wrAddr[g]}]         = wrRise[g];
                    mem[{g[0], wrAddr[g] + 25'h1}] = wrFall[g];
                end
                rdReturn[g] <= rdAccept[g];
                // idle lines flip instead of holding the last pair
                rdRise[g] <= rdAccept[g] ? mem[{g[0], rdAddr[g]}] : ~rdRise[g];
                rdFall[g] <= rdAccept[g] ? mem[{g[0], rdAddr[g] + 25'h1}]
                                         : ~rdFall[g];
            end
    end
endmodule // ddr_bank_model

// ===== test/dual_ddr_backed_fifo_tb.sv
// ------------------------------
// self-checking dual buffer bench
// ------------------------------
module dual_ddr_backed_fifo_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NWORDS = 64;              // words per port, even
    logic                         clk = 1'b0;
    logic                         rst_b = 1'b0;
    ddr_fifo_pkg::word_type [1:0] inData = '0;
    logic [1:0]                   inValid = 2'h0;
    logic [1:0]                   outReady = 2'h0;
    logic [1:0]                   stall = 2'h0;
    wire logic [1:0]              inReady, outValid, wrReq, wrAccept;
    wire logic [1:0]              rdReq, rdAccept, rdReturn;
    wire logic                    portEnable;
    wire logic [4:0]              lamp;
    wire ddr_fifo_pkg::word_type [1:0] outData, wrRise, wrFall, rdRise, rdFall;
    wire ddr_fifo_pkg::addr_type [1:0] wrAddr, rdAddr;
    ddr_fifo_pkg::word_type       q [2][$];  // expected words per port
    int                           failures = 0;
    int                           checks = 0;
    int                           sent [2] = '{0, 0};
    int                           cycles = 0;
    int                           seed = 32'hb9ca;
    logic [31:0]                  rnd;
    always #4 clk = ~clk;
    dual_ddr_backed_fifo #(.MS_CYCLES(4)) dual_ddr_backed_fifo_inst (
        .clk, .rst_b, .inData, .inValid, .inReady, .outData, .outValid,
        .outReady, .portEnable, .wrReq, .wrAddr, .wrRise, .wrFall, .wrAccept,
        .rdReq, .rdAddr, .rdAccept, .rdRise, .rdFall, .rdReturn, .lamp);
    ddr_bank_model ddr_bank_model_inst (
        .clk, .rst_b, .stall, .wrReq, .wrAddr, .wrRise, .wrFall, .wrAccept,
        .rdReq, .rdAddr, .rdAccept, .rdRise, .rdFall, .rdReturn);
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // offers held until taken, random gaps and stalls, hang guard
    always @(posedge clk)
    begin
        cycles++;
        rnd = $random(seed);
        outReady <= rnd[1:0];
        stall    <= rnd[3:2] & rnd[5:4];
        for (int g = 0; g < 2; g++)
        begin
            if (inValid[g] && inReady[g] && portEnable)
            begin
                q[g].push_back(inData[g]);
                sent[g]++;
            end
            if (!inValid[g] || (inReady[g] && portEnable))
            begin
                inValid[g] <= cycles > 8 && sent[g] < NWORDS && rnd[6 + g];
                inData[g]  <= $random(seed);
            end
        end
        if (cycles == 20000)
        begin
            failures++;
            results();
        end
    end
    // words leave each port in arrival order
    always @(posedge clk)
        for (int g = 0; g < 2; g++)
            if (rst_b && outValid[g] && outReady[g] && portEnable)
                cmp(g ? "outB" : "outA", q[g].pop_front(), outData[g]);
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("lampsAfterReset", 32'h5, 32'(lamp[3:0]));
        repeat (100) @(posedge clk);
        cmp("lampAStretch", 32'h1, 32'(lamp[0]));
        while (sent[0] + sent[1] < 2 * NWORDS || q[0].size() + q[1].size() > 0)
            @(posedge clk);
        repeat (2500) @(posedge clk);
        cmp("lampsDrained", 32'h5, 32'(lamp[3:0]));
        results();
    end
endmodule // dual_ddr_backed_fifo_tb
